// ===== src/mdm_master.sv
// management serial master: clause-22 read and write frames to a PHY
// Function
// [R1] host always drives the management clock; the shared-port variant releases it together with the data line; code: inside frames only, idle drives it
// [R2] release data line while PHY returns read data
// [R3] done only after final frame bit shifted
// [R4] default bit clock 1.66 MHz, parameter in hertz
// [R5] shared-port variant samples read on falling edge
// [R6] faster bit clock only if PHY supports it
// [R7] support separate or shared-port pin arrangement
// [R8] shared port: one direction, clock pulled high; code: inside frames only, idle drives the clock low with data released
// [R9] preamble, start, opcode, addresses, turnaround, 16 data
`timescale 1ns/1ps
module mdm_master
  import mdm_pkg::*;
#(
  parameter int unsigned management_bit_rate_setting = mdm_pkg::MDM_BIT_RATE_HZ,
  parameter bit SHARED_PORT = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // request side
  input wire logic req_valid,
  output logic req_ready,
  input wire mdm_pkg::mdm_req_t req,
  output logic done,
  output logic [15:0] rdata,
  // link pins
  output mdm_pkg::mdm_pins_t pins,
  input wire logic mdio_i,
  input wire logic mdc_i
);
  import mdm_pkg::*;

  // half of one bit period; a faster rate is the user's call to make [R6]
  localparam int unsigned HALF_CYC_RAW = MDM_SYS_CLK_HZ / (2 * management_bit_rate_setting);
  localparam int unsigned HALF_CYC = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW; // [R4]
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  typedef enum logic [1:0] {MDM_IDLE, MDM_LOW, MDM_HIGH} mdm_state_t;

  mdm_state_t state_reg, state_next;
  logic [7:0] div_reg, div_next;
  logic [6:0] bit_reg, bit_next;
  logic [63:0] shift_reg, shift_next;
  logic is_read_reg, is_read_next;
  logic [15:0] rdata_reg, rdata_next;
  logic done_reg, done_next;
  logic mdc_reg, mdc_next;
  logic mdio_o_reg, mdio_o_next;
  logic mdio_oe_reg, mdio_oe_next;
  logic mdc_oe_reg, mdc_oe_next;
  logic mdio_s;
  logic mdc_s;

  mdm_sync #(.WIDTH(2)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({mdio_i, mdc_i}),
    .sync_out({mdio_s, mdc_s})
  );

  wire logic div_end = (div_reg == HALF_LAST);
  wire logic in_read_data = is_read_reg && (bit_reg >= 7'(MDM_TA_FIRST_BIT));

  always_comb begin
    state_next = state_reg;
    div_next = div_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    is_read_next = is_read_reg;
    rdata_next = rdata_reg;
    done_next = 1'b0;
    mdc_next = mdc_reg;
    mdio_o_next = mdio_o_reg;
    mdio_oe_next = mdio_oe_reg;
    mdc_oe_next = mdc_oe_reg;
    case (state_reg)
      MDM_IDLE: begin
        mdc_next = 1'b0;
        mdc_oe_next = 1'b1; // [R1]
        mdio_oe_next = 1'b0;
        div_next = '0;
        if (req_valid) begin
          // frame image, shifted out msb first [R9]
          shift_next = {32'hFFFFFFFF, MDM_START_CODE,
                        req.is_read ? MDM_OP_READ : MDM_OP_WRITE,
                        req.phy_addr, req.reg_addr,
                        req.is_read ? 2'h3 : MDM_TA_WRITE,
                        req.is_read ? 16'hFFFF : req.wdata}; // [R9]
          is_read_next = req.is_read;
          bit_next = '0;
          state_next = MDM_LOW;
        end
      end
      MDM_LOW: begin
        // data changes while the clock is low
        if (div_reg == '0) begin
          mdio_o_next = shift_reg[63];
          mdio_oe_next = !(is_read_reg && bit_reg >= 7'(MDM_TA_FIRST_BIT)); // [R2]
          // shared port: one direction bit, clock floats high via pull-up [R7] [R8]
          mdc_oe_next = SHARED_PORT ? mdio_oe_next : 1'b1;
        end
        if (div_end) begin
          div_next = '0;
          mdc_next = 1'b1;
          state_next = MDM_HIGH;
          // two-port variant samples on the rising edge
          if (!SHARED_PORT && in_read_data && bit_reg >= 7'(MDM_DATA_FIRST_BIT)) begin
            rdata_next = {rdata_reg[14:0], mdio_s};
          end
        end else begin
          div_next = div_reg + 8'h01;
        end
      end
      default: begin
        if (div_end) begin
          div_next = '0;
          mdc_next = 1'b0;
          // shared port samples at the falling edge [R5]
          if (SHARED_PORT && in_read_data && bit_reg >= 7'(MDM_DATA_FIRST_BIT)) begin
            rdata_next = {rdata_reg[14:0], mdio_s};
          end
          shift_next = {shift_reg[62:0], 1'b0};
          if (bit_reg == 7'(MDM_FRAME_BITS - 1)) begin
            done_next = 1'b1; // [R3]
            mdio_oe_next = 1'b0;
            mdc_oe_next = 1'b1;
            state_next = MDM_IDLE;
          end else begin
            bit_next = bit_reg + 7'h01;
            state_next = MDM_LOW;
          end
        end else begin
          div_next = div_reg + 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg <= MDM_IDLE;
      div_reg <= '0;
      bit_reg <= '0;
      shift_reg <= '0;
      is_read_reg <= 1'b0;
      rdata_reg <= MDM_DATA_RESET;
      done_reg <= 1'b0;
      mdc_reg <= 1'b0;
      mdio_o_reg <= 1'b0;
      mdio_oe_reg <= 1'b0;
      mdc_oe_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      div_reg <= div_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      is_read_reg <= is_read_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      mdc_reg <= mdc_next;
      mdio_o_reg <= mdio_o_next;
      mdio_oe_reg <= mdio_oe_next;
      mdc_oe_reg <= mdc_oe_next;
    end
  end

  assign req_ready = (state_reg == MDM_IDLE);
  assign done = done_reg;
  assign rdata = rdata_reg;
  // one driver for the whole pin bundle
  assign pins = '{mdc_o: mdc_reg, mdc_oe: mdc_oe_reg,
                  mdio_o: mdio_o_reg, mdio_oe: mdio_oe_reg};

  sequence s_last_fall;
    (state_reg == MDM_HIGH) && div_end && (bit_reg == 7'(MDM_FRAME_BITS - 1));
  endsequence

  AST_DONE_AFTER_LAST: assert property (@(posedge ref_clk) disable iff (!resetn) // [R3]
    s_last_fall |=> done && (state_reg == MDM_IDLE))
    else $error("done not raised after last bit");
  AST_DONE_ONLY_AT_END: assert property (@(posedge ref_clk) disable iff (!resetn) // [R3]
    done |-> $past(state_reg) == MDM_HIGH)
    else $error("done outside frame end");
  AST_MDC_DRIVEN: assert property (@(posedge ref_clk) disable iff (!resetn) // [R1]
    (!SHARED_PORT) |-> pins.mdc_oe)
    else $error("clock line released in two-port variant");
  AST_READ_RELEASE: assert property (@(posedge ref_clk) disable iff (!resetn) // [R2]
    (state_reg != MDM_IDLE && is_read_reg && bit_reg >= 7'(MDM_TA_FIRST_BIT) && div_reg == 8'h01)
      |-> !pins.mdio_oe)
    else $error("data line driven during read return");
  AST_WRITE_DRIVE: assert property (@(posedge ref_clk) disable iff (!resetn) // [R9]
    (state_reg == MDM_HIGH && !is_read_reg) |-> pins.mdio_oe)
    else $error("data line not driven during write");
  AST_SHARED_DIR: assert property (@(posedge ref_clk) disable iff (!resetn) // [R8]
    (SHARED_PORT && state_reg == MDM_HIGH) |-> (pins.mdc_oe == pins.mdio_oe))
    else $error("shared port direction split");
  AST_HALF_PERIOD: assert property (@(posedge ref_clk) disable iff (!resetn) // [R4]
    $changed(pins.mdc_o) |-> ($past(div_reg) == HALF_LAST))
    else $error("clock edge before half period ended");
  AST_PREAMBLE_ONES: assert property (@(posedge ref_clk) disable iff (!resetn) // [R9]
    (state_reg == MDM_HIGH && bit_reg < 7'(MDM_PREAMBLE_BITS)) |-> pins.mdio_o)
    else $error("preamble bit not one");

  sequence s_start_first;
    (state_reg == MDM_HIGH) && (bit_reg == 7'(MDM_PREAMBLE_BITS));
  endsequence
  sequence s_start_second;
    (state_reg == MDM_HIGH) && (bit_reg == 7'(MDM_PREAMBLE_BITS + 1));
  endsequence

  AST_START_FIRST: assert property (@(posedge ref_clk) disable iff (!resetn) // [R9]
    s_start_first |-> (pins.mdio_o == MDM_START_CODE[1]))
    else $error("first start bit wrong");
  AST_START_SECOND: assert property (@(posedge ref_clk) disable iff (!resetn) // [R9]
    s_start_second |-> (pins.mdio_o == MDM_START_CODE[0]))
    else $error("second start bit wrong");
  AST_DATA_STABLE_HIGH: assert property (@(posedge ref_clk) disable iff (!resetn) // [R9]
    (state_reg == MDM_HIGH) |-> $stable(pins.mdio_o))
    else $error("data line changed while clock high");
  AST_DIV_BOUND: assert property (@(posedge ref_clk) disable iff (!resetn) // [R4]
    div_reg <= HALF_LAST)
    else $error("half period counter overran");
  AST_RDATA_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn) // [R2]
    $changed(rdata) |-> (($past(state_reg) != MDM_IDLE) && $past(is_read_reg)))
    else $error("read data changed outside a read frame");
  // the phy never drives the clock line, so it echoes our own drive
  AST_MDC_LINE: assert property (@(posedge ref_clk) disable iff (!resetn) // [R1]
    (!SHARED_PORT && $past(pins.mdc_oe, 2)) |-> (mdc_s == $past(pins.mdc_o, 2)))
    else $error("clock line differs from driven clock");
endmodule : mdm_master

// ===== src/mdm_pkg.sv
// package for the management serial master: constants and carrier types
package mdm_pkg;
  localparam int unsigned MDM_SYS_CLK_HZ = 10000000;
  localparam int unsigned MDM_BIT_RATE_HZ = 1660000;
  localparam int unsigned MDM_PREAMBLE_BITS = 32;
  localparam int unsigned MDM_FRAME_BITS = 64;
  localparam int unsigned MDM_TA_FIRST_BIT = 46;
  localparam int unsigned MDM_DATA_FIRST_BIT = 48;
  localparam logic [1:0] MDM_START_CODE = 2'h1;
  localparam logic [1:0] MDM_OP_WRITE = 2'h1;
  localparam logic [1:0] MDM_OP_READ = 2'h2;
  localparam logic [1:0] MDM_TA_WRITE = 2'h2;
  localparam logic [15:0] MDM_DATA_RESET = 16'h0000;

  typedef struct packed {
    logic is_read;
    logic [4:0] phy_addr;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
  } mdm_req_t;

  // output and enable pair for each line
  typedef struct packed {
    logic mdc_o;
    logic mdc_oe;
    logic mdio_o;
    logic mdio_oe;
  } mdm_pins_t;
endpackage : mdm_pkg

// ===== src/mdm_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module mdm_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : mdm_sync

// ===== test/mdm_phy_model.sv
// behavioural phy answering clause-22 frames from a small register file
`timescale 1ns/1ps
module mdm_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h03,
  parameter int DLY_NS = 40
) (
  // link
  input wire logic mdc,
  input wire logic mdio,
  output logic phy_o,
  output logic phy_oe
);
  logic [33:0] sr = '0;
  int pos = 0;
  logic rd_hit = 1'b0;
  logic wr_hit = 1'b0;
  logic [4:0] ra;
  logic [15:0] mem [32];
  initial begin
    phy_o = 1'b0;
    phy_oe = 1'b0;
  end
  always @(posedge mdc) begin
    sr = {sr[32:0], mdio};
    if (pos == 0 && sr == {{32{1'b1}}, 2'h1}) begin
      pos = 34;
    end else if (pos != 0) begin
      pos = pos + 1;
    end
    if (pos == 46) begin
      rd_hit = sr[11:10] == 2'h2 && sr[9:5] == PHY_ADDR;
      wr_hit = sr[11:10] == 2'h1 && sr[9:5] == PHY_ADDR;
      ra = sr[4:0];
    end
    if (pos == 64) begin
      if (wr_hit) begin
        mem[ra] = sr[15:0];
      end
      rd_hit = 1'b0;
      pos = 0;
    end
  end
  // drive only from the second turnaround bit to the last data bit
  always @(negedge mdc) begin
    if (rd_hit && pos >= 47 && pos <= 63) begin
      phy_oe <= #DLY_NS 1'b1;
      phy_o <= #DLY_NS (pos == 47) ? 1'b0 : mem[ra][63 - pos];
    end else begin
      phy_oe <= #DLY_NS 1'b0;
    end
  end
endmodule : mdm_phy_model

// ===== test/tb.sv
// testbench: management master against the behavioural phy
`timescale 1ns/1ps
module tb;
  import mdm_pkg::*;
  localparam int HALF = MDM_SYS_CLK_HZ / (2 * MDM_BIT_RATE_HZ);
  localparam logic [4:0] PHY = 5'h03;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready;
  logic done;
  logic [15:0] rdata;
  mdm_req_t req = '0;
  mdm_pins_t pins;
  logic phy_o;
  logic phy_oe;
  // pull-ups on both lines
  wire mdc_w = pins.mdc_oe ? pins.mdc_o : 1'b1;
  wire mdio_w = pins.mdio_oe ? pins.mdio_o : (phy_oe ? phy_o : 1'b1);
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int per = 100;
  bit hung = 1'b0;
  logic mdc_q = 1'b0;
  logic [15:0] lfsr = 16'h002E;
  logic [15:0] mem [32];
  logic [15:0] last = MDM_DATA_RESET;
  logic [15:0] q_data [$];
  int q_take [$];
  always #50 ref_clk = ~ref_clk;
  mdm_master #(.management_bit_rate_setting(MDM_BIT_RATE_HZ), .SHARED_PORT(1'b0)) i_dut (.ref_clk(ref_clk),
    .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready), .req(req), .done(done), .rdata(rdata),
    .pins(pins), .mdio_i(mdio_w), .mdc_i(mdc_w));
  mdm_phy_model #(.PHY_ADDR(PHY), .DLY_NS(40)) i_phy (.mdc(mdc_w), .mdio(mdio_w), .phy_o(phy_o),
    .phy_oe(phy_oe));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  function automatic logic [15:0] next_rand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : next_rand
  task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra);
    int n;
    lfsr = next_rand(lfsr);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= {rd, pa, ra, lfsr};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 1000 && !hung);
    req_valid <= 1'b0;
    if (n >= 1000 || hung) begin
      // a hung master stops all further traffic; the report still runs
      hung = 1'b1;
      mismatches++;
      return;
    end
    if (!rd && pa == PHY)
      mem[ra] = lfsr;
    if (rd)
      last = (pa == PHY) ? mem[ra] : 16'hFFFF;
    q_data.push_back(last);
    q_take.push_back(cyc);
  endtask : xfer
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    mdc_q <= pins.mdc_o;
    per <= (pins.mdc_o && !mdc_q) ? 1 : (done ? 100 : per + 1);
    if (done === 1'b1) begin
      check(q_data.size() > 0, 1, "done without request");
      check(req_ready, 1'b1, "ready at done");
      if (q_data.size() > 0) begin
        check(rdata, q_data.pop_front(), "rdata");
        // 64 bits of two half periods each, plus the registered done
        check(cyc - q_take.pop_front(), 128 * HALF + 1, "done latency");
      end
    end
    if (pins.mdc_o === 1'b1)
      check(req_ready, 1'b0, "ready during frame");
    if (pins.mdc_o === 1'b1 && mdc_q === 1'b0 && per < 50)
      check(per, 2 * HALF, "bit period");
    if (phy_oe === 1'b1)
      check(pins.mdio_oe, 1'b0, "data line contention");
    if (cyc > 2)
      check(pins.mdc_oe, 1'b1, "clock drive");
  end
  initial begin
    logic [4:0] ra;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      ra = lfsr[9:5];
      xfer(1'b0, PHY, ra);
      xfer(1'b1, PHY, ra);
      // write to another address must leave this phy untouched
      xfer(1'b0, PHY ^ 5'h01, ra);
      xfer(1'b1, PHY, ra);
      xfer(1'b1, PHY ^ 5'h01, ra);
    end
    for (int n = 0; n < 2000 && q_data.size() > 0; n++)
      @(posedge ref_clk);
    if (q_data.size() > 0)
      mismatches++;
    end_sim();
  end
endmodule : tb
